// [verilog/bdm_data_mem_map.vh]
// Address map and constants for the banked data memory block.
// Assumes inclusion by bdm_data_mem.v only; definitions only.
`ifndef BDM_DATA_MEM_MAP_VH
`define BDM_DATA_MEM_MAP_VH

// Core special registers, byte addresses in the data space
`define BDM_ADDR_INDIRECT_PORT_ZERO  8'h00
`define BDM_ADDR_POINTER_ZERO        8'h01
`define BDM_ADDR_INDIRECT_PORT_ONE   8'h02
`define BDM_ADDR_POINTER_ONE         8'h03
`define BDM_ADDR_BANK_SELECT         8'h04
`define BDM_ADDR_WORK_REGISTER       8'h05
`define BDM_ADDR_PROGRAM_COUNTER_LOW 8'h06
`define BDM_ADDR_TABLE_POINTER_LOW   8'h07
`define BDM_ADDR_TABLE_HIGH_BYTE     8'h08
`define BDM_ADDR_TABLE_POINTER_HIGH  8'h09

// Peripheral special registers handed to the outside
`define BDM_ADDR_EXT_FIRST           8'h0a
`define BDM_ADDR_EXT_LAST            8'h42
`define BDM_ADDR_NONVOLATILE_CTRL    8'h40

// Unused holes in the special area
`define BDM_ADDR_HOLE_A              8'h18
`define BDM_ADDR_HOLE_B              8'h3f
`define BDM_ADDR_UNUSED_FIRST        8'h43
`define BDM_ADDR_UNUSED_LAST         8'h9f

// General purpose storage window, per bank
`define BDM_ADDR_RAM_FIRST           8'ha0
`define BDM_ADDR_RAM_LAST            8'hff
`define BDM_RAM_WORDS_PER_BANK       8'h60
`define BDM_RAM_WORDS_TOTAL          8'hc0

// Reset and read values
`define BDM_BANK_RESET               1'b0
`define BDM_BYTE_ZERO                8'h00
`define BDM_BANK_BIT                 0

// Table read sequencer states
`define BDM_TBL_IDLE                 2'b00
`define BDM_TBL_FETCH                2'b01
`define BDM_TBL_STORE                2'b10

`endif

// [verilog/bdm_data_mem.v]
// Banked data memory decode with the core special registers and table read.
// Assumes a core that issues at most one access per cycle, holds off
// while tableBusy is high, and a program store answering progAddr in-cycle.
//
// Behaviour
// - Data memory is volatile, byte-wide, byte access
// - Two banks of 96 bytes at A0H-FFH
// - Special area shared; 40H control only bank1
// - Space starts at 00H with special registers
// - Unused special locations read back as 00
// - Indirect ports store nothing; access pointer target
// - Port zero bank0 only; port one uses bank
// - Indirect access to ports: read 00, write none
// - Both pointers are real read/write registers
// - Direct addressing always reaches bank 0
// - Bank bit 0 selects bank; bits 7-1 zero
// - Reset clears bank except watchdog power-down reset
// - Special register decode ignores bank selection
// - Working register holds ALU results, no mem-mem move
// - Counter low write jumps within current page
// - Counter low write inserts one dummy cycle
// - Table pointers address program memory, ordinary registers
// - Table read: high byte to register, low to destination
// - Missing program word bits read zero in high byte
// - Table instructions take two cycles
`timescale 1ns/1ps
`include "bdm_data_mem_map.vh"

module bdm_data_mem #(
    parameter PC_WIDTH   = 12,  // Program counter width
    parameter WORD_WIDTH = 16   // Program word width, 9 to 16
) (
    input  wire                  core_clk,
    input  wire                  sys_rst,
    input  wire                  wdtPowerDownRst,
    input  wire [7:0]            memAddr,
    input  wire                  memRdEn,
    input  wire                  memWrEn,
    input  wire [7:0]            memWrData,
    output reg  [7:0]            memRdData,
    output reg                   memRdValid,
    input  wire                  accLoad,
    input  wire [7:0]            accIn,
    output reg  [7:0]            accValue,
    input  wire                  pcAdvance,
    input  wire                  pcJump,
    input  wire [PC_WIDTH-1:0]   pcJumpAddr,
    output reg  [PC_WIDTH-1:0]   pcValue,
    output reg                   pcDummyCycle,
    input  wire                  tableReadReq,
    input  wire [7:0]            tableDestAddr,
    output reg  [15:0]           progAddr,
    input  wire [WORD_WIDTH-1:0] progWord,
    output reg                   tableBusy,
    output reg                   bankSelect,
    output reg  [7:0]            extAddr,
    output reg                   extBankOne,
    output reg                   extWrEn,
    output reg  [7:0]            extWrData,
    output reg                   extRdEn,
    input  wire [7:0]            extRdData
);

    // Special registers held here
    reg [7:0]  pointerZero;           // Indirect port zero pointer
    reg [7:0]  pointerOne;            // Indirect port one pointer
    reg [7:0]  tablePtrLow;           // Table pointer low byte
    reg [7:0]  tablePtrHigh;          // Table pointer high byte
    reg [7:0]  tableHighByte;         // Last fetched high byte
    reg [7:0]  ramStore [0:`BDM_RAM_WORDS_TOTAL-1]; // Both banks, no reset
    reg [1:0]  tblState;              // Table sequencer state
    reg [1:0]  next_tblState;         // Sequencer next state
    reg [7:0]  tblDest;               // Destination of the low byte
    reg [WORD_WIDTH-1:0] tblWord;     // Captured program word
    reg [7:0]  rdHold;                // Internal read result
    reg        rdFromExt;             // Result comes from a peripheral
    reg        rdPending;             // Second read stage due

    // Resolved access
    wire [7:0] wrAddrRaw;             // Address of this cycle's write
    wire [7:0] wrDataRaw;             // Data of this cycle's write
    wire       wrReq;                 // A write happens this cycle
    wire       wrOk;                  // Write location exists
    wire       wrBank;                // Bank the write reaches
    wire [7:0] wrEa;                  // Effective write address
    wire       rdOk;                  // Read location exists
    wire       rdBank;                // Bank the read reaches
    wire [7:0] rdEa;                  // Effective read address
    wire [WORD_WIDTH+7:0] tblWordPad; // Word with a zero byte above it
    wire [7:0] tblHighRaw;            // High part of the word, zero filled
    reg  [7:0] rdValue;               // Internal read mux

    // Resolve an address into the location actually reached
    function [9:0] resolve;
        input [7:0] addr;
        input [7:0] ptrZero;
        input [7:0] ptrOne;
        input       bank;
        reg         indirect;
        reg         useBank;
        reg  [7:0]  ea;
        begin
            indirect = 1'b0;
            useBank  = 1'b0;
            ea       = addr;
            if (addr == `BDM_ADDR_INDIRECT_PORT_ZERO)
            begin
                indirect = 1'b1;
                ea       = ptrZero;
            end
            else if (addr == `BDM_ADDR_INDIRECT_PORT_ONE)
            begin
                indirect = 1'b1;
                useBank  = bank;
                ea       = ptrOne;
            end
            // port reached through a port is refused
            resolve = {~(indirect & ((ea == `BDM_ADDR_INDIRECT_PORT_ZERO) |
                                     (ea == `BDM_ADDR_INDIRECT_PORT_ONE))), useBank, ea};
        end
    endfunction

    // Table store cycle borrows the write path for the low byte
    assign wrReq     = memWrEn | (tblState == `BDM_TBL_STORE);
    assign wrAddrRaw = (tblState == `BDM_TBL_STORE) ? tblDest : memAddr;
    assign wrDataRaw = (tblState == `BDM_TBL_STORE) ? tblWord[7:0] : memWrData;
    assign {wrOk, wrBank, wrEa} = resolve(wrAddrRaw, pointerZero, pointerOne, bankSelect);
    assign {rdOk, rdBank, rdEa} = resolve(memAddr, pointerZero, pointerOne, bankSelect);

    // missing word bits read zero
    // Padding instead of a replication that is empty at full width
    assign tblWordPad = {8'h00, tblWord};
    assign tblHighRaw = tblWordPad[15:8];

    // Is this location a peripheral register outside the block
    function isExt;
        input [7:0] ea;
        begin
            isExt = (ea >= `BDM_ADDR_EXT_FIRST) && (ea <= `BDM_ADDR_EXT_LAST) &&
                    (ea != `BDM_ADDR_HOLE_A) && (ea != `BDM_ADDR_HOLE_B);
        end
    endfunction

    // Index into the two-bank store
    function [7:0] ramIndex;
        input       bank;
        input [7:0] ea;
        reg   [7:0] off;
        begin
            off = ea - `BDM_ADDR_RAM_FIRST;
            ramIndex = bank ? off + `BDM_RAM_WORDS_PER_BANK : off;
        end
    endfunction

    // Internal read mux; holes and peripherals give zero here
    always @*
    begin
        // unused reads 00 unless a case hits
        rdValue = `BDM_BYTE_ZERO;
        if (rdOk)
            case (rdEa)
                `BDM_ADDR_POINTER_ZERO:        rdValue = pointerZero;
                `BDM_ADDR_POINTER_ONE:         rdValue = pointerOne;
                `BDM_ADDR_BANK_SELECT:         rdValue = {7'h00, bankSelect};
                `BDM_ADDR_WORK_REGISTER:       rdValue = accValue;
                `BDM_ADDR_PROGRAM_COUNTER_LOW: rdValue = pcValue[7:0];
                `BDM_ADDR_TABLE_POINTER_LOW:   rdValue = tablePtrLow;
                `BDM_ADDR_TABLE_HIGH_BYTE:     rdValue = tableHighByte;
                `BDM_ADDR_TABLE_POINTER_HIGH:  rdValue = tablePtrHigh;
                default:
                    if (rdEa >= `BDM_ADDR_RAM_FIRST)
                        rdValue = ramStore[ramIndex(rdBank, rdEa)];
            endcase
    end

    // General purpose store, written one byte at a time
    always @(posedge core_clk)
    begin
        if (wrReq && wrOk && wrEa >= `BDM_ADDR_RAM_FIRST)
            ramStore[ramIndex(wrBank, wrEa)] <= wrDataRaw;
    end

    // Bank selection: kept across the watchdog power-down reset
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            bankSelect <= `BDM_BANK_RESET;
        else if (!wdtPowerDownRst && wrReq && wrOk && wrEa == `BDM_ADDR_BANK_SELECT)
            bankSelect <= wrDataRaw[`BDM_BANK_BIT];
    end

    // Pointers, table pointers and working register
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pointerZero  <= `BDM_BYTE_ZERO;
            pointerOne   <= `BDM_BYTE_ZERO;
            tablePtrLow  <= `BDM_BYTE_ZERO;
            tablePtrHigh <= `BDM_BYTE_ZERO;
            accValue     <= `BDM_BYTE_ZERO;
        end
        else
        begin
            if (wrReq && wrOk && wrEa == `BDM_ADDR_POINTER_ZERO)
                pointerZero <= wrDataRaw;
            if (wrReq && wrOk && wrEa == `BDM_ADDR_POINTER_ONE)
                pointerOne <= wrDataRaw;
            if (wrReq && wrOk && wrEa == `BDM_ADDR_TABLE_POINTER_LOW)
                tablePtrLow <= wrDataRaw;
            if (wrReq && wrOk && wrEa == `BDM_ADDR_TABLE_POINTER_HIGH)
                tablePtrHigh <= wrDataRaw;
            // ALU result port, bus write loses
            if (accLoad)
                accValue <= accIn;
            else if (wrReq && wrOk && wrEa == `BDM_ADDR_WORK_REGISTER)
                accValue <= wrDataRaw;
        end
    end

    // Program counter with page-local jump on low-byte write
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pcValue      <= {PC_WIDTH{1'b0}};
            pcDummyCycle <= 1'b0;
        end
        else
        begin
            pcDummyCycle <= 1'b0;
            if (wrReq && wrOk && wrEa == `BDM_ADDR_PROGRAM_COUNTER_LOW)
            begin
                pcValue      <= {pcValue[PC_WIDTH-1:8], wrDataRaw};
                pcDummyCycle <= 1'b1;
            end
            else if (pcJump)
                pcValue <= pcJumpAddr;
            else if (pcAdvance)
                pcValue <= pcValue + {{(PC_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Table sequencer next state
    always @*
    begin
        next_tblState = tblState;
        case (tblState)
            `BDM_TBL_IDLE:
                if (tableReadReq)
                    next_tblState = `BDM_TBL_FETCH;
            `BDM_TBL_FETCH:
                next_tblState = `BDM_TBL_STORE;
            `BDM_TBL_STORE:
                next_tblState = `BDM_TBL_IDLE;
            default:
                next_tblState = `BDM_TBL_IDLE;
        endcase
    end

    // Table read: two busy cycles, fetch then store
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tblState      <= `BDM_TBL_IDLE;
            tblDest       <= `BDM_BYTE_ZERO;
            tblWord       <= {WORD_WIDTH{1'b0}};
            tableHighByte <= `BDM_BYTE_ZERO;
            tableBusy     <= 1'b0;
            progAddr      <= 16'h0000;
        end
        else
        begin
            tblState <= next_tblState;
            tableBusy <= (next_tblState != `BDM_TBL_IDLE);
            if (tblState == `BDM_TBL_IDLE && tableReadReq)
            begin
                progAddr <= {tablePtrHigh, tablePtrLow};
                tblDest  <= tableDestAddr;
            end
            if (tblState == `BDM_TBL_FETCH)
                tblWord <= progWord;
            // high byte kept here, low byte written out
            if (tblState == `BDM_TBL_STORE)
                tableHighByte <= tblHighRaw;
        end
    end

    // Peripheral strobes, one cycle behind the request
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            extAddr    <= `BDM_BYTE_ZERO;
            extBankOne <= 1'b0;
            extWrEn    <= 1'b0;
            extWrData  <= `BDM_BYTE_ZERO;
            extRdEn    <= 1'b0;
        end
        else
        begin
            extWrEn <= 1'b0;
            extRdEn <= 1'b0;
            if (wrReq && wrOk && isExt(wrEa))
            begin
                // bank flag lets 40H pick the control register
                extAddr    <= wrEa;
                extBankOne <= wrBank;
                extWrEn    <= 1'b1;
                extWrData  <= wrDataRaw;
            end
            else if (memRdEn && rdOk && isExt(rdEa))
            begin
                extAddr    <= rdEa;
                extBankOne <= rdBank;
                extRdEn    <= 1'b1;
            end
        end
    end

    // Read pipeline: all reads answer two edges after the request
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdHold     <= `BDM_BYTE_ZERO;
            rdFromExt  <= 1'b0;
            rdPending  <= 1'b0;
            memRdData  <= `BDM_BYTE_ZERO;
            memRdValid <= 1'b0;
        end
        else
        begin
            // port reads return the pointer target
            rdPending <= memRdEn;
            rdHold    <= rdValue;
            rdFromExt <= memRdEn && rdOk && isExt(rdEa);
            memRdValid <= rdPending;
            if (rdPending)
                memRdData <= rdFromExt ? extRdData : rdHold;
        end
    end

endmodule

// [tb/bdm_data_mem_props.sv]
// Port checks for the banked data memory block.
// Assumes one clock domain and an async active-high reset.
`timescale 1ns/1ps
module bdm_data_mem_props #(
    parameter PC_WIDTH = 12
) (
    input wire                core_clk,
    input wire                sys_rst,
    input wire                wdtPowerDownRst,
    input wire [7:0]          memAddr,
    input wire                memRdEn,
    input wire                memWrEn,
    input wire [7:0]          memWrData,
    input wire                memRdValid,
    input wire                accLoad,
    input wire [7:0]          accIn,
    input wire [7:0]          accValue,
    input wire [PC_WIDTH-1:0] pcValue,
    input wire                pcDummyCycle,
    input wire                tableReadReq,
    input wire                tableBusy,
    input wire                bankSelect,
    input wire [7:0]          extAddr,
    input wire                extWrEn,
    input wire                extRdEn
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Core writes the counter low byte
    wire pclWr = memWrEn && memAddr == 8'h06;
    // Unused special-area location
    wire hole = memAddr == 8'h18 || memAddr == 8'h3f || (memAddr >= 8'h43 && memAddr <= 8'h9f);
    // One dummy cycle, never two
    sequence dummy_once;
        pcDummyCycle ##1 !pcDummyCycle;
    endsequence
    // Two busy cycles, then idle again
    sequence busy_twice;
        tableBusy [*2] ##1 !tableBusy;
    endsequence
    read_latency_a: assert property (memRdValid == $past(memRdEn, 2))
        else $error("read answer not two cycles after request");
    bank_write_a: assert property (memWrEn && memAddr == 8'h04 && !wdtPowerDownRst
        |=> bankSelect == $past(memWrData[0])) else $error("bank bit not taken from bit 0");
    bank_hold_a: assert property (wdtPowerDownRst |=> $stable(bankSelect))
        else $error("bank moved during watchdog power-down reset");
    page_jump_a: assert property (pclWr |=> pcValue[7:0] == $past(memWrData)
        && pcValue[PC_WIDTH-1:8] == $past(pcValue[PC_WIDTH-1:8])) else $error("counter low jump wrong");
    dummy_cycle_a: assert property (pclWr |=> dummy_once)
        else $error("dummy cycle missing or too long");
    table_two_a: assert property (tableReadReq && !tableBusy |=> busy_twice)
        else $error("table read not two cycles");
    ext_window_a: assert property (extWrEn || extRdEn |-> extAddr >= 8'h0a && extAddr <= 8'h42
        && extAddr != 8'h18 && extAddr != 8'h3f) else $error("peripheral strobe outside window");
    ram_local_a: assert property (memWrEn && memAddr >= 8'ha0 |=> !extWrEn)
        else $error("general storage write leaked outside");
    hole_quiet_a: assert property (memRdEn && hole |=> !extRdEn)
        else $error("unused location reached a peripheral");
    acc_load_a: assert property (accLoad |=> accValue == $past(accIn))
        else $error("working register did not take the result");
endmodule
bind bdm_data_mem bdm_data_mem_props #(.PC_WIDTH(PC_WIDTH)) u_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .wdtPowerDownRst(wdtPowerDownRst), .memAddr(memAddr),
    .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData), .memRdValid(memRdValid),
    .accLoad(accLoad), .accIn(accIn), .accValue(accValue), .pcValue(pcValue),
    .pcDummyCycle(pcDummyCycle), .tableReadReq(tableReadReq), .tableBusy(tableBusy),
    .bankSelect(bankSelect), .extAddr(extAddr), .extWrEn(extWrEn), .extRdEn(extRdEn)
);

// [tb/bdm_prog_periph.sv]
// Program store and peripheral registers around the block.
// Assumes registered strobes from the block; answers in the same cycle.
`timescale 1ns/1ps
module bdm_prog_periph #(
    parameter WW = 16
) (
    input  wire          core_clk,
    input  wire [15:0]   progAddr,
    output wire [WW-1:0] progWord,
    input  wire [7:0]    extAddr,
    input  wire          extBankOne,
    input  wire          extWrEn,
    input  wire [7:0]    extWrData,
    input  wire          extRdEn,
    output wire [7:0]    extRdData
);
    reg  [7:0]  regs [0:511];  // Peripheral registers, own slot for bank 1 at 40H
    reg  [7:0]  lastRd = 8'h00;  // Last byte driven, inverted when idle
    wire [15:0] word = {progAddr[15:8] ^ progAddr[7:0], progAddr[7:0]};
    // control register only in bank 1
    wire [8:0]  idx = {extBankOne && extAddr == 8'h40, extAddr};
    integer     i;
    initial for (i = 0; i < 512; i = i + 1) regs[i] = 8'h00;
    assign progWord = word[WW-1:0];
    // Idle bus shows no stale data
    assign extRdData = extRdEn ? regs[idx] : ~lastRd;
    // Register update on write strobe
    always @(posedge core_clk)
    begin
        if (extWrEn) regs[idx] <= extWrData;
        if (extRdEn) lastRd <= regs[idx];
    end
endmodule

// [tb/banked_data_memory_access_tb.sv]
// Self-checking bench for the banked data memory block.
// Assumes the program store and peripheral model beside it.
`timescale 1ns/1ps
module banked_data_memory_access_tb;
    reg         core_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         wdtPowerDownRst = 1'b0;
    reg  [7:0]  memAddr = 8'h00;
    reg         memRdEn = 1'b0;
    reg         memWrEn = 1'b0;
    reg  [7:0]  memWrData = 8'h00;
    reg         accLoad = 1'b0;
    reg  [7:0]  accIn = 8'h00;
    reg         pcAdvance = 1'b0;
    reg         pcJump = 1'b0;
    reg  [11:0] pcJumpAddr = 12'h000;
    reg         tableReadReq = 1'b0;
    reg  [7:0]  tableDestAddr = 8'h00;
    wire [7:0]  memRdData, extAddr, extWrData, extRdData, accValue;
    wire [11:0] pcValue, progWord;
    wire [15:0] progAddr;
    wire        memRdValid, pcDummyCycle, tableBusy, bankSelect, extBankOne, extWrEn, extRdEn;
    int         n_mismatch = 0, checks_done = 0;
    int         ram[2][256], ext[512];  // Reference storage
    int         ptr0, ptr1, bnk, acc, pcv, tblp, tbhp, table_high_byte, a, d;
    // Short program word exercises zero fill
    bdm_data_mem #(.PC_WIDTH(12), .WORD_WIDTH(12)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .wdtPowerDownRst(wdtPowerDownRst), .memAddr(memAddr), .memRdEn(memRdEn), .memWrEn(memWrEn),
        .memWrData(memWrData), .memRdData(memRdData), .memRdValid(memRdValid), .accLoad(accLoad),
        .accIn(accIn), .accValue(accValue), .pcAdvance(pcAdvance), .pcJump(pcJump),
        .pcJumpAddr(pcJumpAddr), .pcValue(pcValue), .pcDummyCycle(pcDummyCycle),
        .tableReadReq(tableReadReq), .tableDestAddr(tableDestAddr), .progAddr(progAddr),
        .progWord(progWord), .tableBusy(tableBusy), .bankSelect(bankSelect), .extAddr(extAddr),
        .extBankOne(extBankOne), .extWrEn(extWrEn), .extWrData(extWrData), .extRdEn(extRdEn),
        .extRdData(extRdData));
    bdm_prog_periph #(.WW(12)) u_far (.core_clk(core_clk), .progAddr(progAddr), .progWord(progWord),
        .extAddr(extAddr), .extBankOne(extBankOne), .extWrEn(extWrEn), .extWrData(extWrData),
        .extRdEn(extRdEn), .extRdData(extRdData));
    always #2.5 core_clk = ~core_clk;
    // Reference read of address a in bank b
    function automatic int mval(int a, int b, bit ind);
        if (a == 0 || a == 2) return ind ? 0 : (a == 0 ? mval(ptr0, 0, 1) : mval(ptr1, bnk, 1));
        if (a >= 'ha0) return ram[b][a];
        case (a)
            1: return ptr0;
            3: return ptr1;
            4: return bnk;
            5: return acc;
            6: return pcv & 'hff;
            7: return tblp;
            8: return table_high_byte;
            9: return tbhp;
            'h18, 'h3f: return 0;
        endcase
        return (a <= 'h42) ? ext[(a == 'h40 && b == 1) ? 'h140 : a] : 0;
    endfunction
    // Reference write; ports on ports and holes do nothing
    function automatic void mwr(int a, int b, bit ind, int d);
        if (a == 0 || a == 2) begin
            if (!ind) mwr(a == 0 ? ptr0 : ptr1, a == 0 ? 0 : bnk, 1, d);
        end
        else if (a >= 'ha0) ram[b][a] = d;
        else case (a)
            1: ptr0 = d;
            3: ptr1 = d;
            4: bnk = d & 1;
            5: acc = d;
            6: pcv = (pcv & 'hf00) | d;
            7: tblp = d;
            9: tbhp = d;
            8, 'h18, 'h3f: ;
            default: if (a <= 'h42) ext[(a == 'h40 && b == 1) ? 'h140 : a] = d;
        endcase
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Single write cycle, held until the taking edge
    task automatic wr(int a, int d);
        @(posedge core_clk);
        memAddr <= a[7:0];
        memWrData <= d[7:0];
        memWrEn <= 1'b1;
        @(posedge core_clk);
        memWrEn <= 1'b0;
        mwr(a, 0, 0, d);
    endtask
    // Read; answer stands one edge after the taking edge
    task automatic rd(int a);
        int e;
        e = mval(a, 0, 0);
        @(posedge core_clk);
        memAddr <= a[7:0];
        memRdEn <= 1'b1;
        @(posedge core_clk);
        memRdEn <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(memRdValid, 1);
        chk(memRdData, e);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog, far beyond the expected run
    initial
    begin
        #60000;
        n_mismatch++;
        conclude();
    end
    initial
    begin
        void'($urandom(32'h2e241b4b));
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (a = 0; a < 10; a++) if (a != 8) rd(a);
        $display("reset values done");
        repeat (40)
        begin
            a = 'ha0 + $urandom_range(95);
            wr(a, $urandom_range(255));
            rd(a);
            a = 'h0a + $urandom_range(149);
            wr(a, $urandom_range(255));
            rd(a);
        end
        $display("direct map done");
        wr(4, 'hff);
        rd(4);
        wr(3, 'hb7);
        wr(1, 'hb7);
        wr(2, 'h3c);
        wr(0, 'h5a);
        rd(2);
        rd('hb7);
        wr(3, 'h40);
        wr(2, 'h81);
        wr(4, 0);
        rd(2);
        wr(4, 1);
        rd(2);
        wr(3, 2);
        wr(2, 'h77);
        rd(2);
        wr(1, 0);
        wr(0, 'h66);
        rd(0);
        $display("indirect access done");
        d = $urandom_range(255);
        @(posedge core_clk);
        accLoad <= 1'b1;
        accIn <= d[7:0];
        @(posedge core_clk);
        accLoad <= 1'b0;
        acc = d;
        rd(5);
        @(posedge core_clk);
        pcJumpAddr <= 12'h5c3;
        pcJump <= 1'b1;
        @(posedge core_clk);
        pcJump <= 1'b0;
        pcAdvance <= 1'b1;
        @(posedge core_clk);
        pcAdvance <= 1'b0;
        pcv = 'h5c4;
        wr(6, d);
        #1;
        chk(pcValue, pcv);
        chk(pcDummyCycle, 1);
        @(posedge core_clk);
        #1;
        chk(pcDummyCycle, 0);
        $display("counter done");
        repeat (4)
        begin
            wr(7, $urandom_range(255));
            wr(9, $urandom_range(255));
            a = 'ha0 + $urandom_range(95);
            @(posedge core_clk);
            tableReadReq <= 1'b1;
            tableDestAddr <= a[7:0];
            @(posedge core_clk);
            tableReadReq <= 1'b0;
            #1;
            chk(tableBusy, 1);
            chk(progAddr, tbhp * 256 + tblp);
            @(posedge core_clk);
            #1;
            chk(tableBusy, 1);
            @(posedge core_clk);
            #1;
            chk(tableBusy, 0);
            table_high_byte = (tbhp ^ tblp) & 'h0f;
            ram[0][a] = tblp;
            rd(8);
            rd(a);
        end
        $display("table read done");
        @(posedge core_clk);
        wdtPowerDownRst <= 1'b1;
        wr(4, 0);
        wdtPowerDownRst <= 1'b0;
        bnk = 1;
        rd(4);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk(bankSelect, 0);
        $display("bank reset done");
        conclude();
    end
endmodule
